/* File: verilog/pin_select_pkg.sv */
package pin_select_pkg;
  // register indices on the plain port (word addresses)
  localparam logic [3:0] port_b_low_function_select_addr = 4'h0;
  localparam logic [3:0] port_b_high_control_one_addr = 4'h1;
  localparam logic [3:0] port_e_low_control_one_addr = 4'h2;
  localparam logic [3:0] port_a_low_pin_levels_addr = 4'h3;
  // field positions (low bit of each mode field; three bits wide, except the two-bit pe0 field)
  localparam int pb_pin2_mode_lsb = 8;
  localparam int pb_pin1_mode_lsb = 4;
  localparam int pe_pin3_mode_lsb = 12;
  localparam int pe_pin2_mode_lsb = 8;
  localparam int pe_pin1_mode_lsb = 4;
  localparam int pe_pin0_mode_lsb = 0;
  // writable masks, port a level read mask and control reset value
  localparam logic [15:0] port_b_low_write_mask = 16'h0770;
  localparam logic [15:0] port_e_low_write_mask = 16'h7773;
  localparam logic [15:0] port_a_level_mask = 16'h03db;
  localparam logic [15:0] control_reset_value = 16'h0000;
  // mode codes
  localparam logic [2:0] mode_port = 3'h0;
  localparam logic [2:0] mode_irq = 3'h1;
  localparam logic [2:0] mode_disable = 3'h2;
  localparam logic [2:0] mode_capture = 3'h3;
  localparam logic [2:0] mode_timer = 3'h1;
  localparam logic [2:0] mode_serial = 3'h6;
endpackage : pin_select_pkg

/* File: verilog/port_pin_function_select.sv */
`timescale 1ns/1ps
module port_pin_function_select
  import pin_select_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  // port a pin levels
  input wire logic [15:0] port_a_pins,
  // port b pin 2
  input wire logic pb2_pin_in,
  input wire logic pb2_port_out,
  input wire logic pb2_port_drive,
  output logic pb2_pin_out,
  output logic pb2_pin_oe_n,
  output logic external_interrupt_zero_input,
  output logic output_disable_input_zero,
  // port b pin 1
  input wire logic pb1_pin_in,
  input wire logic pb1_port_out,
  input wire logic pb1_port_drive,
  output logic pb1_pin_out,
  output logic pb1_pin_oe_n,
  output logic timer5_w_capture_input,
  // port e pin 3
  input wire logic pe3_pin_in,
  input wire logic pe3_port_out,
  input wire logic pe3_port_drive,
  input wire logic timer0_d_out,
  input wire logic timer0_d_drive,
  input wire logic serial0_clock_out,
  input wire logic serial0_clock_drive,
  output logic pe3_pin_out,
  output logic pe3_pin_oe_n,
  output logic timer0_d_in,
  output logic serial0_clock_in,
  // port e pin 2
  input wire logic pe2_pin_in,
  input wire logic pe2_port_out,
  input wire logic pe2_port_drive,
  input wire logic timer0_c_out,
  input wire logic timer0_c_drive,
  input wire logic serial0_transmit_out,
  output logic pe2_pin_out,
  output logic pe2_pin_oe_n,
  output logic timer0_c_in,
  // port e pin 1
  input wire logic pe1_pin_in,
  input wire logic pe1_port_out,
  input wire logic pe1_port_drive,
  input wire logic timer0_b_out,
  input wire logic timer0_b_drive,
  output logic pe1_pin_out,
  output logic pe1_pin_oe_n,
  output logic timer0_b_in,
  output logic serial0_receive_in,
  // pin levels seen by the port logic
  output logic [4:0] port_pin_levels,
  // pe0 mode field is stored only; its routing lives outside this block
  output logic [1:0] pe_pin0_mode
);

  logic [15:0] port_b_low_function_select;
  logic [15:0] port_e_low_control_one;
  logic [15:0] next_read_data;

  wire logic write_b_low = write_strobe && address == port_b_low_function_select_addr;
  wire logic write_e_low = write_strobe && address == port_e_low_control_one_addr;

  // masking at write time keeps reserved bits zero in storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_b_low_function_select <= control_reset_value;
      port_e_low_control_one <= control_reset_value;
    end else begin
      if (write_b_low) begin
        port_b_low_function_select <= write_data & port_b_low_write_mask;
      end
      if (write_e_low) begin
        port_e_low_control_one <= write_data & port_e_low_write_mask;
      end
    end
  end

  // read mux; unmapped addresses and the high port b register read zero
  always_comb begin
    case (address)
      port_b_low_function_select_addr: next_read_data = port_b_low_function_select;
      port_b_high_control_one_addr: next_read_data = 16'h0000;
      port_e_low_control_one_addr: next_read_data = port_e_low_control_one;
      port_a_low_pin_levels_addr: next_read_data = port_a_pins & port_a_level_mask;
      default: next_read_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      read_data <= 16'h0000;
    end else begin
      read_data <= read_strobe ? next_read_data : 16'h0000;
    end
  end

  // field extraction; routes come straight from registers so a change is one clean step
  wire logic [2:0] pb2_mode = port_b_low_function_select[pb_pin2_mode_lsb +: 3];
  wire logic [2:0] pb1_mode = port_b_low_function_select[pb_pin1_mode_lsb +: 3];
  wire logic [2:0] pe3_mode = port_e_low_control_one[pe_pin3_mode_lsb +: 3];
  wire logic [2:0] pe2_mode = port_e_low_control_one[pe_pin2_mode_lsb +: 3];
  wire logic [2:0] pe1_mode = port_e_low_control_one[pe_pin1_mode_lsb +: 3];

  // prohibited codes fall back to port behaviour, which is the safest pin state
  wire logic pb2_is_irq = pb2_mode == mode_irq;
  wire logic pb2_is_poe = pb2_mode == mode_disable;
  wire logic pb1_is_cap = pb1_mode == mode_capture;
  wire logic pe3_is_tmr = pe3_mode == mode_timer;
  wire logic pe3_is_sci = pe3_mode == mode_serial;
  wire logic pe2_is_tmr = pe2_mode == mode_timer;
  wire logic pe2_is_sci = pe2_mode == mode_serial;
  wire logic pe1_is_tmr = pe1_mode == mode_timer;
  wire logic pe1_is_sci = pe1_mode == mode_serial;

  // port b pin 2: both alternates are inputs
  assign external_interrupt_zero_input = pb2_is_irq ? pb2_pin_in : 1'b1;
  assign output_disable_input_zero = pb2_is_poe ? pb2_pin_in : 1'b1;
  assign pb2_pin_out = pb2_port_out;
  assign pb2_pin_oe_n = !((pb2_is_irq || pb2_is_poe) ? 1'b0 : pb2_port_drive);

  // port b pin 1
  assign timer5_w_capture_input = pb1_is_cap ? pb1_pin_in : 1'b0;
  assign pb1_pin_out = pb1_port_out;
  assign pb1_pin_oe_n = !(pb1_is_cap ? 1'b0 : pb1_port_drive);

  // port e pin 3
  assign timer0_d_in = pe3_is_tmr ? pe3_pin_in : 1'b0;
  assign serial0_clock_in = pe3_is_sci ? pe3_pin_in : 1'b0;
  assign pe3_pin_out = pe3_is_tmr ? timer0_d_out : pe3_is_sci ? serial0_clock_out : pe3_port_out;
  assign pe3_pin_oe_n = !(pe3_is_tmr ? timer0_d_drive : pe3_is_sci ? serial0_clock_drive : pe3_port_drive);

  // port e pin 2: serial transmit always drives
  assign timer0_c_in = pe2_is_tmr ? pe2_pin_in : 1'b0;
  assign pe2_pin_out = pe2_is_tmr ? timer0_c_out : pe2_is_sci ? serial0_transmit_out : pe2_port_out;
  assign pe2_pin_oe_n = !(pe2_is_tmr ? timer0_c_drive : pe2_is_sci ? 1'b1 : pe2_port_drive);

  // port e pin 1: serial receive idles high when not routed
  assign timer0_b_in = pe1_is_tmr ? pe1_pin_in : 1'b0;
  assign serial0_receive_in = pe1_is_sci ? pe1_pin_in : 1'b1;
  assign pe1_pin_out = pe1_is_tmr ? timer0_b_out : pe1_port_out;
  assign pe1_pin_oe_n = !(pe1_is_tmr ? timer0_b_drive : pe1_is_sci ? 1'b0 : pe1_port_drive);

  assign port_pin_levels = {pe3_pin_in, pe2_pin_in, pe1_pin_in, pb2_pin_in, pb1_pin_in};
  assign pe_pin0_mode = port_e_low_control_one[pe_pin0_mode_lsb +: 2];

  // assertions
  a_pb_mode_reset: assert property (@(posedge clk) !reset_n |=> port_b_low_function_select == 16'h0000)
    else $error("port b mode register not cleared by reset");
  a_pe_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (port_e_low_control_one & ~port_e_low_write_mask) == 16'h0000)
    else $error("reserved port e bits not zero");
  a_pb_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address == port_b_low_function_select_addr |=> (read_data & ~port_b_low_write_mask) == 16'h0000)
    else $error("reserved port b bits read nonzero");
  a_high_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address == port_b_high_control_one_addr |=> read_data == 16'h0000)
    else $error("high port b register read nonzero");
  a_levels_live: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address == port_a_low_pin_levels_addr
    |=> read_data == ($past(port_a_pins) & port_a_level_mask))
    else $error("port a levels not the pin state");
  a_levels_ro: assert property (@(posedge clk) disable iff (!reset_n)
    write_strobe && address == port_a_low_pin_levels_addr |=> $stable(port_e_low_control_one)
    && $stable(port_b_low_function_select))
    else $error("write to level register changed state");
  a_irq_route: assert property (@(posedge clk) disable iff (!reset_n)
    write_b_low && write_data[10:8] == 3'h1 |=> external_interrupt_zero_input == pb2_pin_in && pb2_pin_oe_n)
    else $error("interrupt input not routed a cycle after write");
  a_capture_route: assert property (@(posedge clk) disable iff (!reset_n)
    write_b_low && write_data[6:4] == 3'h3 |=> timer5_w_capture_input == pb1_pin_in)
    else $error("capture input not routed");
  a_sck_route: assert property (@(posedge clk) disable iff (!reset_n)
    write_e_low && write_data[14:12] == 3'h6 |=> pe3_pin_out == serial0_clock_out)
    else $error("serial clock not routed");
  a_txd_route: assert property (@(posedge clk) disable iff (!reset_n)
    write_e_low && write_data[10:8] == 3'h6 |=> pe2_pin_out == serial0_transmit_out && !pe2_pin_oe_n)
    else $error("transmit not driving pin");
  a_rxd_route: assert property (@(posedge clk) disable iff (!reset_n)
    write_e_low && write_data[6:4] == 3'h6 |=> serial0_receive_in == pe1_pin_in && pe1_pin_oe_n)
    else $error("receive not routed");
  a_mode_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !write_e_low |=> $stable(port_e_low_control_one))
    else $error("port e modes changed without a write");

  a_irq_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pb2_is_irq |-> external_interrupt_zero_input)
    else $error("interrupt input not idle high");

  a_irq_pass: assert property (@(posedge clk) disable iff (!reset_n)
    pb2_is_irq |-> external_interrupt_zero_input == pb2_pin_in)
    else $error("interrupt input not following pin");

  a_poe_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pb2_is_poe |-> output_disable_input_zero)
    else $error("disable input not idle high");

  a_poe_pass: assert property (@(posedge clk) disable iff (!reset_n)
    pb2_is_poe |-> output_disable_input_zero == pb2_pin_in)
    else $error("disable input not following pin");

  a_pb2_alt_input: assert property (@(posedge clk) disable iff (!reset_n)
    pb2_is_irq || pb2_is_poe |-> pb2_pin_oe_n)
    else $error("pb2 driven while an input function");

  a_pb2_port_drive: assert property (@(posedge clk) disable iff (!reset_n)
    pb2_mode == mode_port |-> pb2_pin_oe_n == !pb2_port_drive)
    else $error("pb2 port drive not passed");

  a_pb2_port_data: assert property (@(posedge clk) disable iff (!reset_n)
    pb2_pin_out == pb2_port_out)
    else $error("pb2 port data not passed");

  a_cap_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pb1_is_cap |-> !timer5_w_capture_input)
    else $error("capture input not idle low");

  a_cap_pass: assert property (@(posedge clk) disable iff (!reset_n)
    pb1_is_cap |-> timer5_w_capture_input == pb1_pin_in)
    else $error("capture input not following pin");

  a_cap_input: assert property (@(posedge clk) disable iff (!reset_n)
    pb1_is_cap |-> pb1_pin_oe_n)
    else $error("pb1 driven while capture input");

  a_pb1_port_drive: assert property (@(posedge clk) disable iff (!reset_n)
    pb1_mode == mode_port |-> pb1_pin_oe_n == !pb1_port_drive)
    else $error("pb1 port drive not passed");

  a_pb1_port_data: assert property (@(posedge clk) disable iff (!reset_n)
    pb1_pin_out == pb1_port_out)
    else $error("pb1 port data not passed");

  a_pe3_port: assert property (@(posedge clk) disable iff (!reset_n)
    pe3_mode == mode_port |-> pe3_pin_out == pe3_port_out && pe3_pin_oe_n == !pe3_port_drive)
    else $error("pe3 port mode wrong");

  a_pe3_timer: assert property (@(posedge clk) disable iff (!reset_n)
    pe3_is_tmr |-> pe3_pin_out == timer0_d_out && pe3_pin_oe_n == !timer0_d_drive && timer0_d_in == pe3_pin_in)
    else $error("pe3 timer mode wrong");

  a_pe3_serial: assert property (@(posedge clk) disable iff (!reset_n)
    pe3_is_sci |-> pe3_pin_oe_n == !serial0_clock_drive && serial0_clock_in == pe3_pin_in)
    else $error("pe3 serial clock mode wrong");

  a_pe3_timer_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pe3_is_tmr |-> !timer0_d_in)
    else $error("timer d input not idle low");

  a_pe3_serial_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pe3_is_sci |-> !serial0_clock_in)
    else $error("serial clock input not idle low");

  a_pe_mode_reset: assert property (@(posedge clk)
    !reset_n |=> port_e_low_control_one == control_reset_value)
    else $error("port e mode register not cleared by reset");

  a_pe2_port: assert property (@(posedge clk) disable iff (!reset_n)
    pe2_mode == mode_port |-> pe2_pin_out == pe2_port_out && pe2_pin_oe_n == !pe2_port_drive)
    else $error("pe2 port mode wrong");

  a_pe2_timer: assert property (@(posedge clk) disable iff (!reset_n)
    pe2_is_tmr |-> pe2_pin_out == timer0_c_out && pe2_pin_oe_n == !timer0_c_drive && timer0_c_in == pe2_pin_in)
    else $error("pe2 timer mode wrong");

  a_pe2_timer_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pe2_is_tmr |-> !timer0_c_in)
    else $error("timer c input not idle low");

  a_pe1_port: assert property (@(posedge clk) disable iff (!reset_n)
    pe1_mode == mode_port |-> pe1_pin_out == pe1_port_out && pe1_pin_oe_n == !pe1_port_drive)
    else $error("pe1 port mode wrong");

  a_pe1_timer: assert property (@(posedge clk) disable iff (!reset_n)
    pe1_is_tmr |-> pe1_pin_out == timer0_b_out && pe1_pin_oe_n == !timer0_b_drive && timer0_b_in == pe1_pin_in)
    else $error("pe1 timer mode wrong");

  a_pe1_serial: assert property (@(posedge clk) disable iff (!reset_n)
    pe1_is_sci |-> pe1_pin_oe_n && pe1_pin_out == pe1_port_out)
    else $error("pe1 driven while receive input");

  a_pe1_timer_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pe1_is_tmr |-> !timer0_b_in)
    else $error("timer b input not idle low");

  a_rx_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pe1_is_sci |-> serial0_receive_in)
    else $error("receive input not idle high");

  a_pb_mode_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !write_b_low |=> $stable(port_b_low_function_select))
    else $error("port b modes changed without a write");

  a_pb_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
    write_b_low |=> port_b_low_function_select == ($past(write_data) & port_b_low_write_mask))
    else $error("port b write not applied next cycle");

  a_pe_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
    write_e_low |=> port_e_low_control_one == ($past(write_data) & port_e_low_write_mask))
    else $error("port e write not applied next cycle");

  a_read_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !read_strobe |=> read_data == 16'h0000)
    else $error("read data not zero outside a read");

  a_pb_readback: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address == port_b_low_function_select_addr |=> read_data == $past(port_b_low_function_select))
    else $error("port b register read back wrong");

  a_pe_readback: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address == port_e_low_control_one_addr |=> read_data == $past(port_e_low_control_one))
    else $error("port e register read back wrong");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address > port_a_low_pin_levels_addr |=> read_data == 16'h0000)
    else $error("unmapped read nonzero");

  a_pb_store_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (port_b_low_function_select & ~port_b_low_write_mask) == 16'h0000)
    else $error("reserved port b bits stored nonzero");

  a_levels_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    read_strobe && address == port_a_low_pin_levels_addr |=> (read_data & ~port_a_level_mask) == 16'h0000)
    else $error("reserved level bits read nonzero");

endmodule : port_pin_function_select

/* File: tb/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner (
  input wire logic clk,
  output logic [39:0] pv
);
  // pads and peripheral sources move every cycle, so stale routing cannot pass
  initial pv = 40'h00_0000_0000;
  always @(posedge clk) pv <= 40'({$urandom(), $urandom()});
endmodule : pin_partner

/* File: tb/test_port_pin_function_select.sv */
`timescale 1ns/1ps
module test_port_pin_function_select;
  import pin_select_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] address = 4'h0;
  logic [15:0] write_data = 16'h0000;
  logic [15:0] read_data, d;
  logic [39:0] pv;
  logic [4:0] port_pin_levels;
  logic [1:0] pe_pin0_mode;
  logic pb2_pin_out, pb2_pin_oe_n, external_interrupt_zero_input, output_disable_input_zero, pb1_pin_out;
  logic pb1_pin_oe_n, timer5_w_capture_input, pe3_pin_out, pe3_pin_oe_n, timer0_d_in, serial0_clock_in;
  logic pe2_pin_out, pe2_pin_oe_n, timer0_c_in, pe1_pin_out, pe1_pin_oe_n, timer0_b_in, serial0_receive_in;
  logic [15:0] q[$];
  int errors = 0;
  int checked = 0;
  // pv: [15:0] port a, [20:16] pads {pe3,pe2,pe1,pb2,pb1}, [25:21] port data, [30:26] port drive,
  // [33:31] timer out {d,c,b}, [36:34] timer drive, [37] clock out, [38] clock drive, [39] transmit
  pin_partner u_partner (.clk(clk), .pv(pv));
  port_pin_function_select u_dut (.port_a_pins(pv[15:0]), .pb1_pin_in(pv[16]), .pb2_pin_in(pv[17]),
    .pe1_pin_in(pv[18]), .pe2_pin_in(pv[19]), .pe3_pin_in(pv[20]), .pb1_port_out(pv[21]), .pb2_port_out(pv[22]),
    .pe1_port_out(pv[23]), .pe2_port_out(pv[24]), .pe3_port_out(pv[25]), .pb1_port_drive(pv[26]),
    .pb2_port_drive(pv[27]), .pe1_port_drive(pv[28]), .pe2_port_drive(pv[29]), .pe3_port_drive(pv[30]),
    .timer0_b_out(pv[31]), .timer0_c_out(pv[32]), .timer0_d_out(pv[33]), .timer0_b_drive(pv[34]),
    .timer0_c_drive(pv[35]), .timer0_d_drive(pv[36]), .serial0_clock_out(pv[37]), .serial0_clock_drive(pv[38]),
    .serial0_transmit_out(pv[39]), .*);
  initial forever #5 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // each access ends at the falling edge, so routing is looked at settled
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    address <= a;
    write_data <= v;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input bit live);
    @(posedge clk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    q.push_back(live ? (pv[15:0] & port_a_level_mask) : exp);
    read_strobe <= 1'b0;
    @(negedge clk);
  endtask : rd
  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  always @(posedge clk) rd_d <= read_strobe;
  always @(negedge clk) if (reset_n) begin
    if (rd_d) chk("read_data", q.pop_front(), read_data);
    else chk("read_idle", 16'h0000, read_data);
    chk("pin_levels", 16'(pv[20:16]), 16'(port_pin_levels));
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    void'($urandom(29));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("port_mode", {pe3_pin_out, pe2_pin_out, pe1_pin_out, pb2_pin_out, pb1_pin_out, pe3_pin_oe_n, pe2_pin_oe_n,
      pe1_pin_oe_n, pb2_pin_oe_n, pb1_pin_oe_n}, {pv[25:21], ~pv[30:26]});
    chk("idle_inputs", {external_interrupt_zero_input, output_disable_input_zero, serial0_receive_in,
      timer5_w_capture_input, timer0_d_in, timer0_c_in, timer0_b_in, serial0_clock_in}, 16'h00e0);
    rd(port_b_low_function_select_addr, control_reset_value, 0);
    rd(port_e_low_control_one_addr, control_reset_value, 0);
    wr(port_b_low_function_select_addr, 16'hf9bf);
    chk("pb_route", {external_interrupt_zero_input, output_disable_input_zero, timer5_w_capture_input},
      {pv[17], 1'b1, pv[16]});
    chk("pb_input_oe", 16'({pb2_pin_oe_n, pb1_pin_oe_n}), 16'h0003);
    rd(port_b_low_function_select_addr, 16'h0130, 0);
    wr(port_b_low_function_select_addr, 16'h0200);
    chk("pb_disable", {external_interrupt_zero_input, output_disable_input_zero}, {1'b1, pv[17]});
    wr(port_b_high_control_one_addr, 16'hffff);
    rd(port_b_high_control_one_addr, 16'h0000, 0);
    wr(port_a_low_pin_levels_addr, 16'hffff);
    rd(port_a_low_pin_levels_addr, 16'h0000, 1);
    rd(4'h9, 16'h0000, 0);
    wr(port_e_low_control_one_addr, 16'h9991);
    chk("pe_timer", {pe3_pin_out, pe2_pin_out, pe1_pin_out, pe3_pin_oe_n, pe2_pin_oe_n, pe1_pin_oe_n,
      timer0_d_in, timer0_c_in, timer0_b_in}, {pv[33:31], ~pv[36:34], pv[20:18]});
    rd(port_e_low_control_one_addr, 16'h1111, 0);
    wr(port_e_low_control_one_addr, 16'heeef);
    chk("pe_serial", {pe3_pin_out, pe3_pin_oe_n, serial0_clock_in, pe2_pin_out, pe2_pin_oe_n, serial0_receive_in,
      timer0_d_in, timer0_b_in, pe_pin0_mode},
      {pv[37], ~pv[38], pv[20], pv[39], 1'b0, pv[18], 4'h3});
    chk("pe1_receive", 16'({pe1_pin_oe_n, pe1_pin_out, timer0_c_in}), 16'({1'b1, pv[23], 1'b0}));
    rd(port_e_low_control_one_addr, 16'h6663, 0);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(port_e_low_control_one_addr, control_reset_value, 0);
    repeat (8) begin
      d = 16'(16'h0100 * ($urandom() % 3) + 16'h0030 * ($urandom() % 2));
      wr(port_b_low_function_select_addr, d);
      rd(port_b_low_function_select_addr, d, 0);
    end
    conclude();
  end
endmodule : test_port_pin_function_select
